// File: logic/svr_cfg.svh
// Timing constants for the supervisor block
`ifndef SVR_CFG_SVH
`define SVR_CFG_SVH
// Clock period in ns (10 MHz)
`define SVR_CLK_NS        100
// Reset hold time in ms, least value
`define SVR_HOLD_MS       150
// Hold count in cycles, rounded up
`define SVR_HOLD_CYC      ((`SVR_HOLD_MS * 1000000 + `SVR_CLK_NS - 1) / `SVR_CLK_NS)
// Watchdog timeout in ms (typical)
`define SVR_WDOG_MS       1650
`define SVR_WDOG_CYC      ((`SVR_WDOG_MS * 1000000) / `SVR_CLK_NS)
// Chip-select hold time in us (typical)
`define SVR_CS_HOLD_US    12
`define SVR_CS_HOLD_CYC   ((`SVR_CS_HOLD_US * 1000) / `SVR_CLK_NS)
// Least kick pulse width in ns, kept by the processor
`define SVR_KICK_MIN_NS   100
`endif

// File: logic/svr_pkg.sv
// Types for the supervisor block
`default_nettype none
package svr_pkg;
   // Chip-select gate state during a reset event
   typedef enum logic [1:0] {
      SVR_CS_PASS,
      SVR_CS_HOLD,
      SVR_CS_BLOCK
   } svr_cs_state_t;
endpackage : svr_pkg
`default_nettype wire

// File: logic/svr_sync.sv
// Two flip-flop synchroniser for a group of pin inputs
`default_nettype none
module svr_sync #(
   parameter int          WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // Data
   input  wire logic [WIDTH-1:0] d_i,
   output logic      [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;

   // Two stages, first read only by the second
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_ff <= INIT;
         sync_ff <= INIT;
      end else begin
         meta_ff <= d_i;
         sync_ff <= meta_ff;
      end
   end

   assign q_o = sync_ff;
endmodule // svr_sync
`default_nettype wire

// File: logic/svr_supervisor.sv
// Reset supervisor with watchdog, chip-select gating and backup switch
`include "svr_cfg.svh"
// ====================================================================
// Notes on behaviour
// - Reset holds while supply is low, manual reset is low or aux is low.
// - After any cause releases or a watchdog event, reset holds one hold time.
// - The hold time lasts at least 150 ms.
// - A watchdog expiry gives a reset pulse one hold time long.
// - A kick input still for a timeout expires the watchdog, repeatedly.
// - The watchdog clears while reset is asserted and on any kick edge.
// - An active-low reset mirrors the active-high one; high is open-drain.
// - Manual reset low asserts reset, held one hold time after it rises.
// - Aux monitor low asserts reset, held one hold time after it rises.
// - Output supply is main while supply is above threshold, else the greater of main/backup.
// - Below threshold, switch to backup at +20 mV, back at +20 mV main.
// - The backup flag is high only in battery-backup mode.
// - Gated chip-select goes low only when input is low outside reset.
// - Input low at reset entry holds output low 12 us or until input high.
// - Once high during a reset event the output stays high until it ends.
// ====================================================================
`default_nettype none
module svr_supervisor
   import svr_pkg::*;
#(
   parameter int unsigned HOLD_CYC = `SVR_HOLD_CYC,
   parameter int unsigned WDOG_CYC = `SVR_WDOG_CYC,
   parameter int unsigned CS_CYC   = `SVR_CS_HOLD_CYC
) (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // Comparator results (pins)
   input  wire logic supply_ok_i,       // Main above supply_threshold
   input  wire logic backup_above_i,    // Backup exceeds main by 20 mV
   input  wire logic main_above_i,      // Main exceeds backup by 20 mV
   input  wire logic aux_ok_i,          // Aux monitor above 1.235 V
   // Control pins
   input  wire logic manual_reset_n_i,
   input  wire logic watchdog_kick_in_i,
   input  wire logic ce_in_n_i,
   // Reset outputs
   output logic      reset_o,           // Open-drain level, drive low
   output logic      reset_oe_o,
   output logic      reset_n_o,         // Push-pull variant
   output logic      reset_n_oe_o,      // Open-drain variant enable
   // Chip-select and supply
   output logic      ce_out_n_o,
   output logic      sel_backup_o,      // Output supply from backup
   output logic      backup_active_flag_o
);
   localparam int HW = $clog2(HOLD_CYC + 1);
   localparam int WW = $clog2(WDOG_CYC + 1);
   localparam int CW = $clog2(CS_CYC + 1);

   // ================================================================
   // Input synchronisers
   // ================================================================
   logic [5:0] pins_s;
   logic       sup_ok_s;
   logic       bk_above_s;
   logic       mn_above_s;
   logic       aux_ok_s;
   logic       man_rst_n_s;
   logic       kick_s;
   logic       ce_in_n_s;

   svr_sync #(
      .WIDTH (6),
      .INIT  (6'h0)
   ) u_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d_i   ({supply_ok_i, backup_above_i, main_above_i, aux_ok_i,
               manual_reset_n_i, watchdog_kick_in_i}),
      .q_o   (pins_s)
   );

   // Chip-select input, idles high
   svr_sync #(
      .WIDTH (1),
      .INIT  (1'h1)
   ) u_sync_ce (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d_i   (ce_in_n_i),
      .q_o   (ce_in_n_s)
   );

   assign {sup_ok_s, bk_above_s, mn_above_s, aux_ok_s, man_rst_n_s, kick_s} =
          pins_s;

   // ================================================================
   // Reset causes and hold counter
   // ================================================================
   logic          cause;
   logic          wd_fire;
   logic          rst_ff;
   logic          nxt_rst;
   logic [HW-1:0] hold_ff;
   logic [HW-1:0] nxt_hold;

   assign cause = ~sup_ok_s | ~man_rst_n_s | ~aux_ok_s;

   // Hold counter next state
   always_comb begin
      nxt_rst  = rst_ff;
      nxt_hold = hold_ff;
      if (cause) begin
         nxt_rst  = 1'b1;
         nxt_hold = HW'(HOLD_CYC);
      end else if (wd_fire) begin
         nxt_rst  = 1'b1;
         nxt_hold = HW'(HOLD_CYC);
      end else if (rst_ff) begin
         if (hold_ff <= HW'(1)) begin
            nxt_rst  = 1'b0;
            nxt_hold = '0;
         end else begin
            nxt_hold = hold_ff - HW'(1);
         end
      end
   end

   // Hold counter registers, reset asserted at power-up
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rst_ff  <= 1'b1;
         hold_ff <= HW'(HOLD_CYC);
      end else begin
         rst_ff  <= nxt_rst;
         hold_ff <= nxt_hold;
      end
   end

   // ================================================================
   // Watchdog
   // ================================================================
   logic          kick_ff;
   logic          nxt_kick;
   logic [WW-1:0] wd_ff;
   logic [WW-1:0] nxt_wd;

   // expiry after a still kick input
   assign wd_fire = ~rst_ff & (kick_s == kick_ff) &
                    (wd_ff >= WW'(WDOG_CYC - 1));

   // Watchdog next state
   always_comb begin
      nxt_kick = kick_s;
      if (rst_ff || (kick_s != kick_ff)) begin
         nxt_wd = '0;
      end else if (wd_fire) begin
         nxt_wd = '0;
      end else begin
         nxt_wd = wd_ff + WW'(1);
      end
   end

   // Watchdog registers
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         kick_ff <= 1'b0;
         wd_ff   <= '0;
      end else begin
         kick_ff <= nxt_kick;
         wd_ff   <= nxt_wd;
      end
   end

   // ================================================================
   // Reset outputs
   // ================================================================
   // mirrored polarities
   assign reset_o      = 1'b0;
   assign reset_oe_o   = ~rst_ff;     // Release lets pull-up show high
   assign reset_n_o    = ~rst_ff;
   assign reset_n_oe_o = rst_ff;      // Open-drain variant pulls low

   // ================================================================
   // Chip-select gating
   // ================================================================
   svr_cs_state_t cs_ff;
   svr_cs_state_t nxt_cs;
   logic [CW-1:0] cs_cnt_ff;
   logic [CW-1:0] nxt_cs_cnt;
   logic          ce_ff;
   logic          nxt_ce;

   // Gate next state
   always_comb begin
      nxt_cs     = cs_ff;
      nxt_cs_cnt = cs_cnt_ff;
      nxt_ce     = 1'b1;
      unique case (cs_ff)
         SVR_CS_PASS: begin
            nxt_ce = ce_in_n_s;
            if (nxt_rst && !rst_ff) begin
               if (!ce_in_n_s && !ce_ff) begin
                  nxt_cs     = SVR_CS_HOLD;
                  nxt_cs_cnt = CW'(CS_CYC);
                  nxt_ce     = 1'b0;
               end else begin
                  nxt_cs = SVR_CS_BLOCK;
                  nxt_ce = 1'b1;
               end
            end else if (nxt_rst) begin
               nxt_cs = SVR_CS_BLOCK;
               nxt_ce = 1'b1;
            end
         end
         SVR_CS_HOLD: begin
            // end on input high or time
            if (ce_in_n_s || cs_cnt_ff <= CW'(1)) begin
               nxt_cs = SVR_CS_BLOCK;
               nxt_ce = 1'b1;
            end else begin
               nxt_cs_cnt = cs_cnt_ff - CW'(1);
               nxt_ce     = 1'b0;
            end
         end
         SVR_CS_BLOCK: begin
            nxt_ce = 1'b1;
            if (!nxt_rst) begin
               nxt_cs = SVR_CS_PASS;
               nxt_ce = ce_in_n_s;
            end
         end
      endcase
   end

   // Gate registers
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cs_ff     <= SVR_CS_BLOCK;
         cs_cnt_ff <= '0;
         ce_ff     <= 1'b1;
      end else begin
         cs_ff     <= nxt_cs;
         cs_cnt_ff <= nxt_cs_cnt;
         ce_ff     <= nxt_ce;
      end
   end

   assign ce_out_n_o = ce_ff;

   // ================================================================
   // Backup switchover
   // ================================================================
   logic bk_ff;
   logic nxt_bk;

   always_comb begin
      nxt_bk = bk_ff;
      if (sup_ok_s) begin
         nxt_bk = 1'b0;
      end else if (!bk_ff && bk_above_s) begin
         nxt_bk = 1'b1;
      end else if (bk_ff && mn_above_s) begin
         nxt_bk = 1'b0;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         bk_ff <= 1'b0;
      end else begin
         bk_ff <= nxt_bk;
      end
   end

   assign sel_backup_o         = bk_ff;
   assign backup_active_flag_o = bk_ff;

   // ================================================================
   // Assertions
   // ================================================================
   a_cause_holds_reset: assert property (
      @(posedge clk_i) disable iff (rst_i) cause |=> rst_ff)
      else $error("reset not held while a cause is active");

   a_hold_restart: assert property (
      @(posedge clk_i) disable iff (rst_i)
      cause |=> hold_ff == HW'(HOLD_CYC))
      else $error("hold count not restarted by a cause");

   a_hold_release: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (rst_ff && !cause && !wd_fire && hold_ff > HW'(1)) |=> rst_ff)
      else $error("reset released before the hold ended");

   a_wdog_pulse: assert property (
      @(posedge clk_i) disable iff (rst_i)
      wd_fire |=> rst_ff && wd_ff == '0)
      else $error("watchdog expiry gave no reset pulse");

   a_wdog_clear: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (rst_ff || $changed(kick_s)) |=> wd_ff == '0)
      else $error("watchdog not cleared");

   a_reset_mirror: assert property (
      @(posedge clk_i) disable iff (rst_i)
      reset_n_o == reset_oe_o && reset_n_oe_o == rst_ff)
      else $error("reset outputs disagree");

   a_ce_low_gate: assert property (
      @(posedge clk_i) disable iff (rst_i)
      $fell(ce_out_n_o) |-> !rst_ff && !$past(ce_in_n_s))
      else $error("chip-select fell in reset or with input high");

   a_ce_block_high: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (cs_ff == SVR_CS_BLOCK && nxt_rst) |=> ce_out_n_o)
      else $error("chip-select dropped during reset event");

   a_backup_main: assert property (
      @(posedge clk_i) disable iff (rst_i)
      sup_ok_s |=> !sel_backup_o)
      else $error("backup chosen while main above threshold");

   a_flag_follows: assert property (
      @(posedge clk_i) disable iff (rst_i)
      (!sup_ok_s && !bk_ff && bk_above_s) |=> backup_active_flag_o)
      else $error("backup flag missing in backup mode");
endmodule // svr_supervisor
`default_nettype wire

// File: bench/svr_cpu_model.sv
// Processor-side model: watchdog kicker and chip-select driver
`default_nettype none
module svr_cpu_model #(
   parameter int KICK_CYC = 10
) (
   // Clock
   input  wire logic clk_i,
   // Control from the bench
   input  wire logic kick_en_i,
   input  wire logic ce_req_n_i,
   // Pins toward the supervisor
   output var  logic watchdog_kick_in_o,
   output wire logic ce_in_n_o
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt = 0;
   initial watchdog_kick_in_o = 1'b0;
   // toggle kick inside timeout
   // Rising edge, clear of the bench's falling-edge stimulus
   always @(posedge clk_i) begin
      cnt <= (cnt == KICK_CYC - 1) ? 0 : cnt + 1;
      if (kick_en_i && cnt == KICK_CYC - 1) begin
         watchdog_kick_in_o <= ~watchdog_kick_in_o;
      end
   end
   // Chip-select follows the access request
   assign ce_in_n_o = ce_req_n_i;
endmodule // svr_cpu_model
`default_nettype wire

// File: bench/testbench.sv
// Self-checking bench for the reset supervisor
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int HOLD = 40;
   localparam int WDOG = 60;
   localparam int CSC  = 20;
   logic clk_i = 1'b0;
   logic rst_i, supply_ok, backup_above, main_above, aux_ok;
   logic man_rst_n, kick_en, ce_req_n;
   wire logic kick, ce_in_n, reset_o, reset_oe, reset_n, reset_n_oe;
   wire logic ce_out_n, sel_backup, bk_flag;
   wire logic [3:0] outs = {reset_o, reset_oe, reset_n, reset_n_oe};
   int num_errors = 0;
   int checked = 0;
   int n;

   // ==========================================================
   // Instances
   svr_supervisor #(.HOLD_CYC(HOLD), .WDOG_CYC(WDOG), .CS_CYC(CSC)) dut (
      .clk_i(clk_i), .rst_i(rst_i), .supply_ok_i(supply_ok),
      .backup_above_i(backup_above), .main_above_i(main_above),
      .aux_ok_i(aux_ok), .manual_reset_n_i(man_rst_n),
      .watchdog_kick_in_i(kick), .ce_in_n_i(ce_in_n),
      .reset_o(reset_o), .reset_oe_o(reset_oe), .reset_n_o(reset_n),
      .reset_n_oe_o(reset_n_oe), .ce_out_n_o(ce_out_n),
      .sel_backup_o(sel_backup), .backup_active_flag_o(bk_flag));
   svr_cpu_model cpu (
      .clk_i(clk_i), .kick_en_i(kick_en), .ce_req_n_i(ce_req_n),
      .watchdog_kick_in_o(kick), .ce_in_n_o(ce_in_n));

   // ==========================================================
   // Helpers
   task automatic cyc(input int c);
      repeat (c) @(negedge clk_i);
   endtask
   task automatic chk(input logic [3:0] got, input logic [3:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t got %0h exp %0h", $time, got, exp);
      end
   endtask
   function automatic logic [3:0] inr(input int v, lo, hi);
      return {3'h0, v >= lo && v <= hi};
   endfunction
   // Wait, bounded, for the active-low reset to reach a level
   task automatic wait_rst(input logic lvl, input int lim, output int w);
      w = 0;
      while (reset_n !== lvl && w < lim) begin
         cyc(1);
         w++;
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_power_up;
      cyc(HOLD);
      chk(outs, 4'h1);
      cyc(10);
      chk(outs, 4'h6);
   endtask
   task automatic t_causes;
      for (int w = 0; w < 3; w++) begin
         case (w)
            0: supply_ok = 0;
            1: man_rst_n = 0;
            default: aux_ok = 0;
         endcase
         cyc(4);
         chk(outs, 4'h1);
         cyc(6);
         supply_ok = 1;
         man_rst_n = 1;
         aux_ok = 1;
         cyc(HOLD);
         chk(outs, 4'h1);
         cyc(10);
         chk(outs, 4'h6);
      end
   endtask
   task automatic t_restart;
      man_rst_n = 0;
      cyc(6);
      man_rst_n = 1;
      cyc(HOLD / 2);
      man_rst_n = 0;
      cyc(2);
      man_rst_n = 1;
      cyc(HOLD);
      chk(outs, 4'h1);
      cyc(10);
      chk(outs, 4'h6);
   endtask
   task automatic t_watchdog;
      kick_en = 0;
      wait_rst(0, WDOG + 10, n);
      chk(inr(n, WDOG - 14, WDOG + 6), 4'h1);
      wait_rst(1, HOLD + 10, n);
      chk(inr(n, HOLD, HOLD + 4), 4'h1);
      wait_rst(0, WDOG + 10, n);
      chk(inr(n, WDOG - 3, WDOG + 3), 4'h1);
      kick_en = 1;
      wait_rst(1, HOLD + 10, n);
      cyc(3 * WDOG);
      chk(outs, 4'h6);
   endtask
   task automatic t_ce_gate;
      ce_req_n = 0;
      cyc(4);
      chk({3'h0, ce_out_n}, 4'h0);
      man_rst_n = 0;
      wait_rst(0, 6, n);
      cyc(1);
      chk({3'h0, ce_out_n}, 4'h0);
      cyc(CSC - 3);
      chk({3'h0, ce_out_n}, 4'h0);
      cyc(6);
      chk({3'h0, ce_out_n}, 4'h1);
      ce_req_n = 1;
      cyc(4);
      ce_req_n = 0;
      cyc(4);
      chk({3'h0, ce_out_n}, 4'h1);
      man_rst_n = 1;
      wait_rst(1, HOLD + 10, n);
      cyc(4);
      chk({3'h0, ce_out_n}, 4'h0);
      man_rst_n = 0;
      wait_rst(0, 6, n);
      cyc(1);
      ce_req_n = 1;
      cyc(5);
      chk({3'h0, ce_out_n}, 4'h1);
      ce_req_n = 0;
      cyc(4);
      chk({3'h0, ce_out_n}, 4'h1);
      man_rst_n = 1;
      ce_req_n = 1;
      wait_rst(1, HOLD + 10, n);
      cyc(4);
      chk({3'h0, ce_out_n}, 4'h1);
   endtask
   task automatic t_backup;
      supply_ok = 0;
      backup_above = 1;
      cyc(5);
      chk({2'h0, sel_backup, bk_flag}, 4'h3);
      backup_above = 0;
      cyc(5);
      chk({2'h0, sel_backup, bk_flag}, 4'h3);
      main_above = 1;
      cyc(5);
      chk({2'h0, sel_backup, bk_flag}, 4'h0);
      main_above = 0;
      backup_above = 1;
      cyc(5);
      chk({2'h0, sel_backup, bk_flag}, 4'h3);
      supply_ok = 1;
      cyc(5);
      chk({2'h0, sel_backup, bk_flag}, 4'h0);
      backup_above = 0;
      wait_rst(1, HOLD + 10, n);
   endtask

   // ==========================================================
   // Clock, watchdog and main sequence
   initial begin
      forever #50 clk_i = ~clk_i;
   end
   initial begin
      #500000;
      num_errors++;
      report_and_stop();
   end
   initial begin
      rst_i = 1;
      supply_ok = 1;
      backup_above = 0;
      main_above = 0;
      aux_ok = 1;
      man_rst_n = 1;
      kick_en = 1;
      ce_req_n = 1;
      cyc(3);
      rst_i = 0;
      t_power_up();
      t_causes();
      t_restart();
      t_watchdog();
      t_ce_gate();
      t_backup();
      report_and_stop();
   end
endmodule // testbench
`default_nettype wire
